// ===== inc/sxr_map.svh
// register offsets, field positions and reset values of the transceiver control block
`ifndef SXR_MAP_SVH
`define SXR_MAP_SVH

`define SXR_ADDR_W          12
`define SXR_CTRL_OFS        12'h000
`define SXR_STAT_OFS        12'h004

`define SXR_CTRL_START_BIT  0
`define SXR_CTRL_MODE_LSB   1
`define SXR_CTRL_MODE_MSB   2
`define SXR_CTRL_LTR_BIT    3
`define SXR_CTRL_LTD_BIT    4
`define SXR_CTRL_RST        5'h00

`define SXR_STAT_REQ_BIT    0
`define SXR_STAT_DONE_BIT   1
`define SXR_STAT_RDY_BIT    2
`define SXR_STAT_LCK_BIT    3
`define SXR_STAT_LCKA_BIT   4
`define SXR_STAT_ALT_BIT    5
`define SXR_STAT_FSM_LSB    6
`define SXR_STAT_FSM_MSB    7
`define SXR_STAT_CMPL_BIT   8

`define SXR_RCFG_IN_W       70
`define SXR_RCFG_OUT_W      46
`define SXR_SYNC_W          6

`endif

// ===== inc/sxr_pkg.sv
// types shared by the transceiver control block
`default_nettype none
package sxr_pkg;
    typedef enum logic [1:0] {
        SXR_IDLE = 2'h0,
        SXR_REQ  = 2'h1,
        SXR_BUSY = 2'h3,
        SXR_HOLD = 2'h2
    } sxr_fsm_e;

    typedef enum logic [1:0] {
        SXR_RATE_SINGLE = 2'h0,
        SXR_RATE_DUAL   = 2'h1,
        SXR_RATE_TRIPLE = 2'h2,
        SXR_RATE_MULTI  = 2'h3
    } sxr_rate_e;
endpackage
`default_nettype wire

// ===== hw/sxr_sync.sv
// two-flop synchroniser for a bundle of asynchronous levels
`default_nettype none
module sxr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sxr_sync_s;

    sxr_sync_s st_r;
    sxr_sync_s st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.meta   = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;
endmodule
`default_nettype wire

// ===== hw/sxr_ctrl.sv
// transceiver-facing control: refclk select, pll lock, reconfig buses and rx handshake
//
// The APB slave port and the address map were decided locally.
`include "sxr_map.svh"
`default_nettype none
// Functional notes
// - select 0 uses primary reference clock, 1 the alternate; only with dynamic switching
// - one pll lock output, plus separate alternate lock when dynamic switching enabled
// - reconfig bus into transceiver is 70 bits per reconfiguration interface
// - reconfig bus from transceiver is 46 bits per reconfiguration interface
// - second-link serial and reconfig buses exist only in dual-link operation
// - in dual/triple/multi-rate receive, hold reconfig request until completion reported
// - earlier generation completes on done high, later generation on done low
// - later generation: lock-to-reference output forces manual cdr reference lock
// - later generation: lock-to-data output drives transceiver lock-to-data control
module sxr_ctrl
    import sxr_pkg::*;
#(
    parameter bit DYN_SWITCH = 1'b0,
    parameter bit DUAL_LINK  = 1'b0,
    parameter bit RX_ONLY    = 1'b0,
    parameter bit LATER_GEN  = 1'b0,
    parameter int N_IF       = RX_ONLY ? 1 : 2
) (
    input  wire logic                            mclk,
    input  wire logic                            reset,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [`SXR_ADDR_W-1:0]          paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            refclk_sel_pin,
    output logic                                 refclk_use_alt,
    input  wire logic                            pll_locked_raw,
    input  wire logic                            pll_alt_locked_raw,
    output logic                                 tx_pll_locked,
    output logic                                 tx_pll_locked_alt,
    input  wire logic [`SXR_RCFG_IN_W*N_IF-1:0]  mgr_reconfig_in,
    input  wire logic [`SXR_RCFG_IN_W*N_IF-1:0]  mgr_reconfig_in_second,
    output logic      [`SXR_RCFG_IN_W*N_IF-1:0]  phy_reconfig_in_bus,
    output logic      [`SXR_RCFG_IN_W*N_IF-1:0]  phy_reconfig_in_bus_second,
    input  wire logic [`SXR_RCFG_OUT_W*N_IF-1:0] phy_reconfig_out,
    input  wire logic [`SXR_RCFG_OUT_W*N_IF-1:0] phy_reconfig_out_second,
    output logic      [`SXR_RCFG_OUT_W*N_IF-1:0] mgr_reconfig_out,
    output logic      [`SXR_RCFG_OUT_W*N_IF-1:0] mgr_reconfig_out_second,
    input  wire logic                            core_tx_serial,
    input  wire logic                            core_tx_serial_second,
    output logic                                 sdi_tx_serial,
    output logic                                 sdi_tx_serial_second,
    input  wire logic                            sdi_rx_serial,
    input  wire logic                            sdi_rx_serial_second,
    output logic                                 core_rx_serial,
    output logic                                 core_rx_serial_second,
    input  wire logic                            rate_change,
    input  wire logic                            rx_reconfig_done,
    input  wire logic                            rx_phy_ready,
    output logic                                 rx_start_reconfig,
    output logic                                 rx_lock_to_ref,
    output logic                                 rx_lock_to_data
);
    localparam int IN_W  = `SXR_RCFG_IN_W * N_IF;
    localparam int OUT_W = `SXR_RCFG_OUT_W * N_IF;

    typedef struct packed {
        logic [31:0]      rdata;
        logic             start_pend;
        sxr_rate_e        mode;
        logic             ltr_sw;
        logic             ltd_sw;
        sxr_fsm_e         fsm;
        logic             req;
        logic             cmpl;
        logic             use_alt;
        logic             lck;
        logic             lck_alt;
        logic             ltr;
        logic             ltd;
        logic [IN_W-1:0]  rin_a;
        logic [IN_W-1:0]  rin_b;
        logic [OUT_W-1:0] rout_a;
        logic [OUT_W-1:0] rout_b;
        logic             txs_a;
        logic             txs_b;
        logic             rxs_a;
        logic             rxs_b;
    } sxr_ctrl_s;

    sxr_ctrl_s st_r;
    sxr_ctrl_s st_nxt;

    logic [`SXR_SYNC_W-1:0] async_bundle;
    logic [`SXR_SYNC_W-1:0] sync_bundle;
    logic                   sel_s;
    logic                   lck_s;
    logic                   lcka_s;
    logic                   done_s;
    logic                   rdy_s;
    logic                   rxa_s;
    logic                   rxb_s;
    logic                   acc;
    logic                   setup;
    logic                   wr;
    logic                   hit;

    // every pin-side level except the second-link receive serial crosses through the same two-flop stage
    assign async_bundle = {sdi_rx_serial, rx_phy_ready, rx_reconfig_done,
                           pll_alt_locked_raw, pll_locked_raw, refclk_sel_pin};

    sxr_sync #(
        .WIDTH    (`SXR_SYNC_W)
    ) u_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in (async_bundle),
        .sync_out (sync_bundle)
    );

    // second-link receive serial has its own stage; unused when single link
    sxr_sync #(
        .WIDTH    (1)
    ) u_sync_b (
        .mclk     (mclk),
        .reset    (reset),
        .async_in (sdi_rx_serial_second),
        .sync_out (rxb_s)
    );

    assign {rxa_s, rdy_s, done_s, lcka_s, lck_s, sel_s} = sync_bundle;

    function automatic logic addr_is(input logic [`SXR_ADDR_W-1:0] a,
                                     input logic [`SXR_ADDR_W-1:0] ofs);
        addr_is = (a == ofs);
    endfunction

    assign setup = psel & ~penable;
    assign acc   = psel & penable;
    assign wr    = acc & pwrite;
    assign hit   = addr_is(paddr, `SXR_CTRL_OFS) | addr_is(paddr, `SXR_STAT_OFS);

    always_comb begin
        logic rate_multi;
        logic fin;
        logic start_ok;
        logic cmpl_set;
        logic [31:0] stat;
        rate_multi = 1'b0;
        fin        = 1'b0;
        start_ok   = 1'b0;
        cmpl_set   = 1'b0;
        stat       = 32'h0;
        st_nxt     = st_r;

        // control register write
        if (wr && addr_is(paddr, `SXR_CTRL_OFS)) begin
            st_nxt.mode   = sxr_rate_e'(pwdata[`SXR_CTRL_MODE_MSB:`SXR_CTRL_MODE_LSB]);
            st_nxt.ltr_sw = pwdata[`SXR_CTRL_LTR_BIT];
            st_nxt.ltd_sw = pwdata[`SXR_CTRL_LTD_BIT];
        end

        rate_multi = (st_r.mode != SXR_RATE_SINGLE);
        // later parts must not start before the receive phy is out of reset
        start_ok   = rate_multi && (!LATER_GEN || rdy_s);

        if (rate_change || (wr && addr_is(paddr, `SXR_CTRL_OFS)
                            && pwdata[`SXR_CTRL_START_BIT])) begin
            st_nxt.start_pend = rate_multi;
        end

        unique case (st_r.fsm)
            SXR_IDLE: begin
                if (st_r.start_pend && start_ok) begin
                    st_nxt.fsm        = SXR_REQ;
                    st_nxt.req        = 1'b1;
                    if (!rate_change) begin
                        st_nxt.start_pend = 1'b0;
                    end
                end
            end
            SXR_REQ: begin
                // earlier parts finish on done rising, later parts acknowledge by raising it
                if (done_s) begin
                    if (LATER_GEN) begin
                        st_nxt.fsm = SXR_BUSY;
                    end else begin
                        st_nxt.fsm = SXR_HOLD;
                        fin        = 1'b1;
                    end
                end
            end
            SXR_BUSY: begin
                if (!done_s) begin
                    st_nxt.fsm = SXR_IDLE;
                    fin        = 1'b1;
                end
            end
            SXR_HOLD: begin
                // wait for the status to drop so one completion is not seen twice
                if (!done_s) begin
                    st_nxt.fsm = SXR_IDLE;
                end
            end
        endcase
        if (fin) begin
            st_nxt.req = 1'b0;
            cmpl_set   = 1'b1;
        end

        // completion flag: write one to clear, a new completion wins
        if (wr && addr_is(paddr, `SXR_STAT_OFS) && pwdata[`SXR_STAT_CMPL_BIT]) begin
            st_nxt.cmpl = 1'b0;
        end
        if (cmpl_set) begin
            st_nxt.cmpl = 1'b1;
        end

        st_nxt.use_alt = DYN_SWITCH & sel_s;
        st_nxt.lck     = lck_s;
        st_nxt.lck_alt = DYN_SWITCH & lcka_s;
        st_nxt.ltr     = LATER_GEN & st_r.ltr_sw;
        st_nxt.ltd     = LATER_GEN & st_r.ltd_sw & rdy_s;

        st_nxt.rin_a   = mgr_reconfig_in;
        st_nxt.rout_a  = phy_reconfig_out;
        st_nxt.rin_b   = DUAL_LINK ? mgr_reconfig_in_second : '0;
        st_nxt.rout_b  = DUAL_LINK ? phy_reconfig_out_second : '0;
        st_nxt.txs_a   = core_tx_serial;
        st_nxt.txs_b   = DUAL_LINK & core_tx_serial_second;
        st_nxt.rxs_a   = rxa_s;
        st_nxt.rxs_b   = DUAL_LINK & rxb_s;

        stat[`SXR_STAT_REQ_BIT]                     = st_r.req;
        stat[`SXR_STAT_DONE_BIT]                    = done_s;
        stat[`SXR_STAT_RDY_BIT]                     = rdy_s;
        stat[`SXR_STAT_LCK_BIT]                     = st_r.lck;
        stat[`SXR_STAT_LCKA_BIT]                    = st_r.lck_alt;
        stat[`SXR_STAT_ALT_BIT]                     = st_r.use_alt;
        stat[`SXR_STAT_FSM_MSB:`SXR_STAT_FSM_LSB]   = st_r.fsm;
        stat[`SXR_STAT_CMPL_BIT]                    = st_r.cmpl;

        // read data is captured in the setup cycle so prdata leaves a flop
        if (setup) begin
            if (addr_is(paddr, `SXR_CTRL_OFS)) begin
                st_nxt.rdata = {27'h0, st_r.ltd_sw, st_r.ltr_sw, st_r.mode, 1'b0};
            end else if (addr_is(paddr, `SXR_STAT_OFS)) begin
                st_nxt.rdata = stat;
            end else begin
                st_nxt.rdata = 32'h0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r      <= '0;
            st_r.mode <= sxr_rate_e'(2'(`SXR_CTRL_RST >> `SXR_CTRL_MODE_LSB));
            st_r.fsm  <= SXR_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready                     = 1'b1;
    assign pslverr                    = acc & ~hit;
    assign prdata                     = st_r.rdata;
    assign refclk_use_alt             = st_r.use_alt;
    assign tx_pll_locked              = st_r.lck;
    assign tx_pll_locked_alt          = st_r.lck_alt;
    assign rx_start_reconfig          = st_r.req;
    assign rx_lock_to_ref             = st_r.ltr;
    assign rx_lock_to_data            = st_r.ltd;
    assign phy_reconfig_in_bus        = st_r.rin_a;
    assign phy_reconfig_in_bus_second = st_r.rin_b;
    assign mgr_reconfig_out           = st_r.rout_a;
    assign mgr_reconfig_out_second    = st_r.rout_b;
    assign sdi_tx_serial              = st_r.txs_a;
    assign sdi_tx_serial_second       = st_r.txs_b;
    assign core_rx_serial             = st_r.rxs_a;
    assign core_rx_serial_second      = st_r.rxs_b;
endmodule
`default_nettype wire

// ===== verification/sxr_ctrl_monitor.sv
// assertion checker for the transceiver control block
`include "sxr_map.svh"
`default_nettype none
module sxr_ctrl_monitor #(
    parameter bit DYN_SWITCH = 1'b0,
    parameter bit DUAL_LINK  = 1'b0,
    parameter bit LATER_GEN  = 1'b0,
    parameter int N_IF       = 2
) (
    input wire logic                            mclk,
    input wire logic                            reset,
    input wire logic                            refclk_sel_pin,
    input wire logic                            refclk_use_alt,
    input wire logic                            pll_locked_raw,
    input wire logic                            pll_alt_locked_raw,
    input wire logic                            tx_pll_locked,
    input wire logic                            tx_pll_locked_alt,
    input wire logic [`SXR_RCFG_IN_W*N_IF-1:0]  mgr_reconfig_in,
    input wire logic [`SXR_RCFG_IN_W*N_IF-1:0]  mgr_reconfig_in_second,
    input wire logic [`SXR_RCFG_IN_W*N_IF-1:0]  phy_reconfig_in_bus,
    input wire logic [`SXR_RCFG_IN_W*N_IF-1:0]  phy_reconfig_in_bus_second,
    input wire logic [`SXR_RCFG_OUT_W*N_IF-1:0] phy_reconfig_out,
    input wire logic [`SXR_RCFG_OUT_W*N_IF-1:0] mgr_reconfig_out,
    input wire logic                            rx_reconfig_done,
    input wire logic                            rx_start_reconfig,
    input wire logic                            rx_lock_to_ref,
    input wire logic                            rx_lock_to_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // synchronised levels need five quiet samples after reset to settle
    a_alt_select: assert property ((!reset && $stable(refclk_sel_pin))[*5]
        |-> refclk_use_alt == (refclk_sel_pin & DYN_SWITCH)) else $error("alt select wrong");
    a_pll_lock: assert property ((!reset && $stable(pll_locked_raw))[*5]
        |-> tx_pll_locked == pll_locked_raw) else $error("pll lock wrong");
    a_alt_lock: assert property ((!reset && $stable(pll_alt_locked_raw))[*5]
        |-> tx_pll_locked_alt == (pll_alt_locked_raw & DYN_SWITCH)) else $error("alt lock wrong");
    a_cfg_in_copy: assert property (!$past(reset)
        |-> phy_reconfig_in_bus == $past(mgr_reconfig_in)) else $error("reconfig in wrong");
    a_cfg_out_copy: assert property (!$past(reset)
        |-> mgr_reconfig_out == $past(phy_reconfig_out)) else $error("reconfig out wrong");
    a_second_link: assert property (!$past(reset) |-> phy_reconfig_in_bus_second ==
        (DUAL_LINK ? $past(mgr_reconfig_in_second) : '0)) else $error("second bus wrong");
    a_req_hold: assert property (!LATER_GEN && rx_start_reconfig && !rx_reconfig_done
        && !$past(rx_reconfig_done) && !$past(rx_reconfig_done, 2) |=> rx_start_reconfig)
        else $error("request dropped early");
    a_req_release: assert property ((!LATER_GEN && rx_start_reconfig && rx_reconfig_done)[*3]
        |-> ##[1:2] !rx_start_reconfig) else $error("request not released");
    a_lock_ctl_off: assert property (!LATER_GEN |-> !rx_lock_to_ref && !rx_lock_to_data)
        else $error("lock control active");
endmodule
bind sxr_ctrl sxr_ctrl_monitor #(.DYN_SWITCH(DYN_SWITCH), .DUAL_LINK(DUAL_LINK),
    .LATER_GEN(LATER_GEN), .N_IF(N_IF)) i_mon (.mclk, .reset, .refclk_sel_pin,
    .refclk_use_alt, .pll_locked_raw, .pll_alt_locked_raw, .tx_pll_locked, .tx_pll_locked_alt,
    .mgr_reconfig_in, .mgr_reconfig_in_second, .phy_reconfig_in_bus, .phy_reconfig_in_bus_second,
    .phy_reconfig_out, .mgr_reconfig_out, .rx_reconfig_done, .rx_start_reconfig,
    .rx_lock_to_ref, .rx_lock_to_data);
`default_nettype wire

// ===== verification/sxr_mgr_model.sv
// reconfiguration manager and reset controller model, earlier generation handshake
`default_nettype none
module sxr_mgr_model (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       rx_start_reconfig,
    input wire logic [7:0] lat,
    output logic           rx_reconfig_done,
    output logic           rx_phy_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt <= 8'h00;
            rx_reconfig_done <= 1'b0;
            rx_phy_ready <= 1'b0;
        end else begin
            rx_phy_ready <= 1'b1;
            // status rises lat+1 cycles after the request and falls once it is withdrawn
            if (rx_start_reconfig && !rx_reconfig_done) begin
                if (cnt == lat) rx_reconfig_done <= 1'b1;
                else cnt <= cnt + 8'h01;
            end else if (!rx_start_reconfig) begin
                cnt <= 8'h00;
                rx_reconfig_done <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the transceiver control block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic         mclk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [7:0]   lat;
    logic         refclk_sel_pin, refclk_use_alt, pll_locked_raw, pll_alt_locked_raw;
    logic         tx_pll_locked, tx_pll_locked_alt, rate_change, rx_reconfig_done;
    logic         rx_phy_ready, rx_start_reconfig, rx_lock_to_ref, rx_lock_to_data;
    logic         core_tx_serial, core_tx_serial_second, sdi_tx_serial, sdi_tx_serial_second;
    logic         sdi_rx_serial, sdi_rx_serial_second, core_rx_serial, core_rx_serial_second;
    logic [139:0] mgr_reconfig_in, mgr_reconfig_in_second;
    logic [139:0] phy_reconfig_in_bus, phy_reconfig_in_bus_second;
    logic [91:0]  phy_reconfig_out, phy_reconfig_out_second;
    logic [91:0]  mgr_reconfig_out, mgr_reconfig_out_second;
    int           n_fail, total_checks;
    sxr_ctrl #(.DYN_SWITCH(1'b1), .DUAL_LINK(1'b1)) i_dut (.mclk, .reset, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .refclk_sel_pin, .refclk_use_alt,
        .pll_locked_raw, .pll_alt_locked_raw, .tx_pll_locked, .tx_pll_locked_alt,
        .mgr_reconfig_in, .mgr_reconfig_in_second, .phy_reconfig_in_bus,
        .phy_reconfig_in_bus_second, .phy_reconfig_out, .phy_reconfig_out_second,
        .mgr_reconfig_out, .mgr_reconfig_out_second, .core_tx_serial, .core_tx_serial_second,
        .sdi_tx_serial, .sdi_tx_serial_second, .sdi_rx_serial, .sdi_rx_serial_second,
        .core_rx_serial, .core_rx_serial_second, .rate_change, .rx_reconfig_done,
        .rx_phy_ready, .rx_start_reconfig, .rx_lock_to_ref, .rx_lock_to_data);
    sxr_mgr_model i_mgr (.mclk, .reset, .rx_start_reconfig, .lat, .rx_reconfig_done,
        .rx_phy_ready);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [139:0] e, input logic [139:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // entered just after a rising edge; leaves one idle cycle behind it
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task t_regs();
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 0, rd);
        apb(1'b1, 12'h000, 32'h0000001e);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl readback", 32'h1e, rd);
        chk("lock controls", 0, {rx_lock_to_ref, rx_lock_to_data});
        apb(1'b1, 12'h008, 32'hffffffff);
        chk("unmapped err", 1, err);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped data", 0, rd);
        apb(1'b1, 12'h000, 32'h0);
        $display("test regs done");
    endtask
    task t_paths();
        logic [139:0] a;
        logic [91:0]  b;
        logic [91:0]  c;
        for (int i = 0; i < 2; i++) begin
            a = i ? ~{4{35'h2a5a5c3c3}} : {4{35'h2a5a5c3c3}};
            b = i ? ~{4{23'h5ac3c3}} : {4{23'h5ac3c3}};
            c = ~b;
            mgr_reconfig_in <= a;
            mgr_reconfig_in_second <= ~a;
            phy_reconfig_out <= b;
            phy_reconfig_out_second <= c;
            core_tx_serial <= i[0];
            core_tx_serial_second <= !i[0];
            sdi_rx_serial <= !i[0];
            sdi_rx_serial_second <= i[0];
            repeat (4) @(posedge mclk);
            chk("cfg in", a, phy_reconfig_in_bus);
            chk("cfg in second", ~a, phy_reconfig_in_bus_second);
            chk("cfg out", b, mgr_reconfig_out);
            chk("cfg out second", c, mgr_reconfig_out_second);
            chk("tx serial", {i[0], !i[0]}, {sdi_tx_serial, sdi_tx_serial_second});
            chk("rx serial", {!i[0], i[0]}, {core_rx_serial, core_rx_serial_second});
        end
        $display("test paths done");
    endtask
    task t_clk();
        for (int i = 1; i >= 0; i--) begin
            refclk_sel_pin <= i[0];
            pll_locked_raw <= i[0];
            pll_alt_locked_raw <= !i[0];
            repeat (5) @(posedge mclk);
            chk("use alt", i[0], refclk_use_alt);
            chk("pll lock", i[0], tx_pll_locked);
            chk("alt lock", !i[0], tx_pll_locked_alt);
        end
        $display("test clocks done");
    endtask
    task t_reconfig(input logic [1:0] mode, input logic [7:0] l, input logic by_reg);
        int n;
        lat <= l;
        apb(1'b1, 12'h000, {29'h0, mode, 1'b0});
        if (by_reg) apb(1'b1, 12'h000, {29'h0, mode, 1'b1});
        else begin
            rate_change <= 1'b1;
            @(posedge mclk);
            rate_change <= 1'b0;
        end
        n = 0;
        while (rx_start_reconfig !== 1'b1 && n < 8) begin
            @(posedge mclk);
            n++;
        end
        chk("request raised", mode != 2'h0, rx_start_reconfig);
        if (mode != 2'h0) begin
            n = 0;
            while (rx_reconfig_done !== 1'b1 && n < 300) begin
                chk("request held", 1, rx_start_reconfig);
                @(posedge mclk);
                n++;
            end
            if (n >= 300) begin
                n_fail++;
                results();
            end
            n = 0;
            while (rx_start_reconfig === 1'b1 && n < 8) begin
                @(posedge mclk);
                n++;
            end
            chk("request released", 0, rx_start_reconfig);
            apb(1'b0, 12'h004, 32'h0);
            chk("completion flag", 1, rd[8]);
            apb(1'b1, 12'h004, 32'h00000100);
            apb(1'b0, 12'h004, 32'h0);
            chk("completion cleared", 0, rd[8]);
        end
        $display("test reconfig mode %0d done", mode);
    endtask
    initial begin
        n_fail = 0;
        total_checks = 0;
        reset <= 1'b1;
        {psel, penable, pwrite, rate_change, refclk_sel_pin} <= 5'h00;
        {pll_locked_raw, pll_alt_locked_raw, core_tx_serial, core_tx_serial_second} <= 4'h0;
        {sdi_rx_serial, sdi_rx_serial_second} <= 2'h0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        lat <= 8'h00;
        mgr_reconfig_in <= '0;
        mgr_reconfig_in_second <= '0;
        phy_reconfig_out <= '0;
        phy_reconfig_out_second <= '0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        t_regs();
        t_paths();
        t_clk();
        t_reconfig(2'h0, 8'h00, 1'b0);
        t_reconfig(2'h1, 8'h00, 1'b0);
        t_reconfig(2'h2, 8'h28, 1'b1);
        t_reconfig(2'h3, 8'h03, 1'b0);
        results();
    end
endmodule
`default_nettype wire
